// *** rpa_pkg.sv ***
package rpa_pkg;

  // ---------------------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------------------
  localparam int AXI_ADDR_W = 16;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [15:0] MAIN_IDX = 16'h100e;
  localparam logic [15:0] MASK_IDX = 16'h1024;
  localparam logic [15:0] FLAG_IDX = 16'h1025;
  localparam logic [15:0] CTL_IDX = 16'h1026;
  localparam logic [15:0] CNT_IDX = 16'h1027;
  localparam logic [15:0] MAIN_ADDR = {MAIN_IDX[13:0], 2'b00};
  localparam logic [15:0] MASK_ADDR = {MASK_IDX[13:0], 2'b00};
  localparam logic [15:0] FLAG_ADDR = {FLAG_IDX[13:0], 2'b00};
  localparam logic [15:0] CTL_ADDR = {CTL_IDX[13:0], 2'b00};
  localparam logic [15:0] CNT_ADDR = {CNT_IDX[13:0], 2'b00};

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int FLG_CNT_WRAP_BIT = 7;
  localparam int FLG_PERIODIC_BIT = 6;
  localparam int FLG_PA_WRAP_BIT = 5;
  localparam int FLG_PA_EDGE_BIT = 4;
  localparam int FLG_LO_BIT = 4;
  localparam int FLG_N = 4;
  localparam int CTL_DIR7_BIT = 7;
  localparam int CTL_PA_ON_BIT = 6;
  localparam int CTL_MODE_BIT = 5;
  localparam int CTL_EDGE_BIT = 4;
  localparam int CTL_DIR3_BIT = 3;
  localparam int CTL_C4C5_BIT = 2;
  localparam int CTL_RATE_HI = 1;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RTI_BASE_LOG2_DEF = 13;
  localparam int RTI_DIV_W = 16;
  localparam int PA_DIV = 64;
  localparam int PA_DIV_W = $clog2(PA_DIV);
  localparam logic [PA_DIV_W-1:0] PA_DIV_LAST = PA_DIV_W'(PA_DIV - 1);
  localparam logic [7:0] PA_CNT_MAX = 8'hff;
  localparam logic [15:0] MAIN_CNT_MAX = 16'hffff;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_MAIN,
    REG_MASK,
    REG_FLAG,
    REG_CTL,
    REG_CNT
  } rpa_reg_e;

  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } rpa_axi_in_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } rpa_axi_out_s;

  typedef struct packed {
    logic dir7;
    logic pa_on;
    logic mode;
    logic edge_sel;
    logic dir3;
    logic c4c5_sel;
    logic [1:0] rate;
  } rpa_ctl_s;

  typedef struct packed {
    rpa_axi_out_s axi;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] waddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic [15:0] main_cnt;
    logic [RTI_DIV_W-1:0] rti_div;
    logic [PA_DIV_W-1:0] pa_div;
    logic pin_prev;
    rpa_ctl_s ctl;
    logic [FLG_N-1:0] mask;
    logic [FLG_N-1:0] flags;
    logic [7:0] pa_cnt;
    logic irq;
  } rpa_state_s;

  localparam rpa_state_s RST_STATE = '0;

endpackage

// *** rpa_src.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// pulse source on the accumulator input
// ----------------------------------------
module rpa_src (
  input wire logic aclk,
  output logic pin
);
  initial pin = 1'b0;
  // every level lasts at least one clock, so never above half the clock rate
  task automatic burst(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge aclk);
      pin <= 1'b1;
      repeat (half) @(posedge aclk);
      pin <= 1'b0;
    end
  endtask
  task automatic hold(input logic lv, input int cyc);
    @(posedge aclk);
    pin <= lv;
    repeat (cyc) @(posedge aclk);
  endtask
endmodule

// *** rpa_sva.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// port-level checks on the timer block
// ----------------------------------------
module rpa_sva
  import rpa_pkg::*;
#(
  parameter int RTI_BASE_LOG2 = RTI_BASE_LOG2_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire rpa_axi_in_s axi_in,
  input wire rpa_axi_out_s axi_out,
  input wire logic pulse_input_pin,
  input wire logic irq_request,
  input wire logic capture4_compare5_sel,
  input wire logic porta_dir_bit7,
  input wire logic porta_dir_bit3
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_bresp_held: assert property (axi_out.bvalid && !axi_in.bready |=> axi_out.bvalid && $stable(axi_out.bresp))
    else $error("write response not held");
  chk_rdata_held: assert property (axi_out.rvalid && !axi_in.rready |=> axi_out.rvalid && $stable(axi_out.rdata))
    else $error("read data not held");
  chk_write_busy: assert property (axi_out.bvalid |-> !axi_out.awready && !axi_out.wready)
    else $error("write accepted while response pending");
  chk_read_busy: assert property (axi_out.rvalid |-> !axi_out.arready)
    else $error("read accepted while data pending");
  chk_rdata_byte: assert property (axi_out.rvalid |-> axi_out.rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_slverr_zero: assert property (axi_out.rvalid && axi_out.rresp == RESP_SLVERR |-> axi_out.rdata == 32'h0)
    else $error("error read returned data");
  chk_sel_by_write: assert property ($changed(capture4_compare5_sel) |-> ##[0:1] $rose(axi_out.bvalid))
    else $error("select changed without a write");
  chk_irq_drop: assert property ($fell(irq_request) |-> ##[0:1] $rose(axi_out.bvalid))
    else $error("request dropped without a write");
endmodule

// *** rpa_top.sv ***
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - periodic interval 2^13..2^16 cycles by rate
// - periodic divider free-running, only reset or ce low stops
// - interval measured from previous timeout
// - timeout sets flag; enabled flag requests interrupt
// - first flag after one full interval
// - write one to bit 6 clears periodic
// - main counter wrap sets wrap flag
// - accumulator enable gates counting and edge flag
// - mode bit selects events or gated time
// - event mode: edge select picks falling/rising
// - gated mode counts divide-by-64 while active
// - gated inhibit level chosen by edge select
// - count readable, writable anytime, reset keeps it
// - increments never collide with register reads
// - count wrap sets flag; bit 5 clears
// - wrap enable only gates its request
// - selected edge sets edge flag; bit 4 clears
// - edge enable only gates its request
// - select bit drives capture4/compare5 choice out
// - flag bits pair with mask bits by position
module rpa_top
  import rpa_pkg::*;
#(
  parameter int RTI_BASE_LOG2 = RTI_BASE_LOG2_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire rpa_axi_in_s axi_in,
  output rpa_axi_out_s axi_out,
  input wire logic pulse_input_pin,
  output logic irq_request,
  output logic capture4_compare5_sel,
  output logic porta_dir_bit7,
  output logic porta_dir_bit3
);

  // ---------------------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------------------
  function automatic rpa_reg_e reg_sel(input logic [AXI_ADDR_W-1:0] addr);
    case (addr)
      MAIN_ADDR: reg_sel = REG_MAIN;
      MASK_ADDR: reg_sel = REG_MASK;
      FLAG_ADDR: reg_sel = REG_FLAG;
      CTL_ADDR: reg_sel = REG_CTL;
      CNT_ADDR: reg_sel = REG_CNT;
      default: reg_sel = REG_NONE;
    endcase
  endfunction

  // true on the last cycle of an interval of 2^(base+rate) cycles
  function automatic logic rti_expired(input logic [RTI_DIV_W-1:0] div, input logic [1:0] rate);
    logic [RTI_DIV_W:0] span;
    logic [RTI_DIV_W-1:0] low;
    span = (RTI_DIV_W+1)'(1) << (RTI_BASE_LOG2 + int'(rate));
    low = RTI_DIV_W'(span - (RTI_DIV_W+1)'(1));
    rti_expired = ((div & low) == low);
  endfunction

  function automatic logic [7:0] flags_byte(input logic [FLG_N-1:0] f);
    flags_byte = {f, 4'h0};
  endfunction

  rpa_state_s st_r;
  rpa_state_s st_nxt;

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic do_write;
    logic do_read;
    rpa_reg_e wsel;
    rpa_reg_e rsel;
    logic [FLG_N-1:0] flag_set;
    logic [FLG_N-1:0] flag_clr;
    logic rise;
    logic fall;
    logic sel_edge;
    logic gate_open;
    logic pa_inc;
    logic cnt_write;
    do_write = 1'b0;
    do_read = 1'b0;
    wsel = REG_NONE;
    rsel = REG_NONE;
    flag_set = '0;
    flag_clr = '0;
    rise = 1'b0;
    fall = 1'b0;
    sel_edge = 1'b0;
    gate_open = 1'b0;
    pa_inc = 1'b0;
    cnt_write = 1'b0;
    st_nxt = st_r;

    // -------------------------------------------------------------------------
    // write channel: address and data taken in either order
    // -------------------------------------------------------------------------
    if (st_r.axi.bvalid && axi_in.bready) begin
      st_nxt.axi.bvalid = 1'b0;
    end
    if (axi_in.awvalid && st_r.axi.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr = axi_in.awaddr;
    end
    if (axi_in.wvalid && st_r.axi.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wbyte = axi_in.wdata[7:0];
      st_nxt.wlane0 = axi_in.wstrb[0];
    end
    if (st_r.aw_got && st_r.w_got && !st_r.axi.bvalid) begin
      do_write = 1'b1;
      wsel = reg_sel(st_r.waddr);
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.axi.bvalid = 1'b1;
      st_nxt.axi.bresp = (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    st_nxt.axi.awready = !st_nxt.aw_got && !st_nxt.axi.bvalid;
    st_nxt.axi.wready = !st_nxt.w_got && !st_nxt.axi.bvalid;

    // -------------------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------------------
    if (st_r.axi.rvalid && axi_in.rready) begin
      st_nxt.axi.rvalid = 1'b0;
    end
    if (axi_in.arvalid && st_r.axi.arready) begin
      do_read = 1'b1;
      rsel = reg_sel(axi_in.araddr);
      st_nxt.axi.rvalid = 1'b1;
      st_nxt.axi.rresp = (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      // the value captured is the one registered before this edge's
      // increment, so a read sees a settled count
      case (rsel)
        REG_MAIN: st_nxt.axi.rdata = {16'h0000, st_r.main_cnt};
        REG_MASK: st_nxt.axi.rdata = {24'h000000, flags_byte(st_r.mask)};
        REG_FLAG: st_nxt.axi.rdata = {24'h000000, flags_byte(st_r.flags)};
        REG_CTL: st_nxt.axi.rdata = {24'h000000, st_r.ctl};
        REG_CNT: st_nxt.axi.rdata = {24'h000000, st_r.pa_cnt};
        default: st_nxt.axi.rdata = '0;
      endcase
    end
    st_nxt.axi.arready = !st_nxt.axi.rvalid && !do_read;

    // -------------------------------------------------------------------------
    // register writes (low byte lane only)
    // -------------------------------------------------------------------------
    if (do_write && st_r.wlane0) begin
      case (wsel)
        REG_MASK: st_nxt.mask = st_r.wbyte[7:FLG_LO_BIT];
        REG_FLAG: flag_clr = st_r.wbyte[7:FLG_LO_BIT];
        REG_CTL: st_nxt.ctl = st_r.wbyte;
        REG_CNT: cnt_write = 1'b1;
        default: ;
      endcase
    end

    // -------------------------------------------------------------------------
    // main counter and periodic divider
    // -------------------------------------------------------------------------
    st_nxt.main_cnt = st_r.main_cnt + 16'h0001;
    if (st_r.main_cnt == MAIN_CNT_MAX) begin
      flag_set[FLG_CNT_WRAP_BIT-FLG_LO_BIT] = 1'b1;
    end
    // divider never reloads on flag clear or rate change
    st_nxt.rti_div = st_r.rti_div + RTI_DIV_W'(1);
    if (rti_expired(st_r.rti_div, st_r.ctl.rate)) begin
      flag_set[FLG_PERIODIC_BIT-FLG_LO_BIT] = 1'b1;
    end

    // -------------------------------------------------------------------------
    // pulse accumulator
    // -------------------------------------------------------------------------
    // pin is sampled as synchronous; legal only if it toggles at most
    // once per cycle, so one previous sample is enough
    st_nxt.pin_prev = pulse_input_pin;
    rise = pulse_input_pin && !st_r.pin_prev;
    fall = !pulse_input_pin && st_r.pin_prev;
    sel_edge = st_r.ctl.edge_sel ? rise : fall;
    st_nxt.pa_div = st_r.pa_div + PA_DIV_W'(1);
    gate_open = st_r.ctl.edge_sel ? !pulse_input_pin : pulse_input_pin;
    if (st_r.ctl.pa_on) begin
      if (st_r.ctl.mode) begin
        pa_inc = gate_open && (st_r.pa_div == PA_DIV_LAST);
      end else begin
        pa_inc = sel_edge;
      end
      flag_set[FLG_PA_EDGE_BIT-FLG_LO_BIT] = sel_edge;
    end
    if (cnt_write) begin
      st_nxt.pa_cnt = st_r.wbyte;
    end else if (pa_inc) begin
      st_nxt.pa_cnt = st_r.pa_cnt + 8'h01;
      if (st_r.pa_cnt == PA_CNT_MAX) begin
        flag_set[FLG_PA_WRAP_BIT-FLG_LO_BIT] = 1'b1;
      end
    end

    // -------------------------------------------------------------------------
    // flags and request
    // -------------------------------------------------------------------------
    for (int i = 0; i < FLG_N; i++) begin
      st_nxt.flags[i] = (st_r.flags[i] && !flag_clr[i]) || flag_set[i];
    end
    // enables gate only the request, never the flags
    st_nxt.irq = |(st_nxt.flags & st_nxt.mask);

    // -------------------------------------------------------------------------
    // reset keeps the pulse count
    // -------------------------------------------------------------------------
    if (!aresetn) begin
      st_nxt = RST_STATE;
      st_nxt.pa_cnt = st_r.pa_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || ce) begin
      st_r <= st_nxt;
    end
  end

  assign axi_out = st_r.axi;
  assign irq_request = st_r.irq;
  assign capture4_compare5_sel = st_r.ctl.c4c5_sel;
  assign porta_dir_bit7 = st_r.ctl.dir7;
  assign porta_dir_bit3 = st_r.ctl.dir3;

endmodule

// *** rti_pulse_accumulator_test.sv ***
`timescale 1ns/1ns
module rti_pulse_accumulator_test;
  import rpa_pkg::*;
  // short periodic base keeps the run brief
  localparam int B = 6;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  rpa_axi_in_s axi_in = '0;
  rpa_axi_out_s axi_out;
  logic pulse_input_pin, irq_request, capture4_compare5_sel, porta_dir_bit7, porta_dir_bit3;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h37;
  always #5 aclk = ~aclk;
  rpa_top #(.RTI_BASE_LOG2(B)) u_rpa_top (.aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_in(axi_in),
    .axi_out(axi_out), .pulse_input_pin(pulse_input_pin), .irq_request(irq_request),
    .capture4_compare5_sel(capture4_compare5_sel), .porta_dir_bit7(porta_dir_bit7), .porta_dir_bit3(porta_dir_bit3));
  rpa_src u_rpa_src (.aclk(aclk), .pin(pulse_input_pin));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic final_report();
    $display("mismatches %0d of %0d checks", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bready waits for bvalid, so a held response is exercised
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    axi_in.awvalid <= 1'b1;
    axi_in.awaddr <= a;
    axi_in.wvalid <= 1'b1;
    axi_in.wdata <= {24'h0, d};
    axi_in.wstrb <= 4'hf;
    do begin
      @(posedge aclk);
      if (axi_out.awready) axi_in.awvalid <= 1'b0;
      if (axi_out.wready) axi_in.wvalid <= 1'b0;
    end while (!axi_out.bvalid);
    axi_in.bready <= 1'b1;
    @(posedge aclk);
    r = axi_out.bresp;
    axi_in.bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    axi_in.arvalid <= 1'b1;
    axi_in.araddr <= a;
    do begin
      @(posedge aclk);
      if (axi_out.arready) axi_in.arvalid <= 1'b0;
    end while (!axi_out.rvalid);
    axi_in.rready <= 1'b1;
    @(posedge aclk);
    d = axi_out.rdata;
    r = axi_out.rresp;
    axi_in.rready <= 1'b0;
  endtask
  task automatic wait_irq();
    do @(posedge aclk); while (irq_request !== 1'b1);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 85000) begin
      errors++;
      final_report();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    longint t0;
    longint tr;
    logic [31:0] m;
    int n, e, pre, msk, ex;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t0 = $time;
    rd(CTL_ADDR, d, r);
    chk(d, 32'h0);
    rd(MASK_ADDR, d, r);
    chk(d, 32'h0);
    wr(MASK_ADDR, 8'h40, r);
    wait_irq();
    chk(32'(($time - t0) / 10 inside {[63:67]}), 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(CTL_ADDR, 8'(k), r);
      wr(FLAG_ADDR, 8'h40, r);
      wait_irq();
      wr(FLAG_ADDR, 8'h00, r);
      rd(FLAG_ADDR, d, r);
      chk(d & 32'h40, 32'h40);
      wr(FLAG_ADDR, 8'h40, r);
      wait_irq();
      t0 = $time;
      wr(FLAG_ADDR, 8'h40, r);
      wait_irq();
      chk(32'(($time - t0) / 10), 32'(1 << (B + k)));
    end
    wr(CTL_ADDR, 8'h8c, r);
    chk({29'h0, porta_dir_bit7, porta_dir_bit3, capture4_compare5_sel}, 32'h7);
    rd(CTL_ADDR, d, r);
    chk(d, 32'h8c);
    wr(16'h0000, 8'hff, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(16'h0000, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 6; i++) begin
      e = i % 2;
      pre = (i < 2) ? 254 : int'(rnd() % 256);
      n = 1 + int'(rnd() % 6);
      msk = (i < 4) ? 'h30 : 0;
      wr(CNT_ADDR, 8'(pre), r);
      wr(MASK_ADDR, 8'(msk), r);
      wr(FLAG_ADDR, 8'h30, r);
      wr(CTL_ADDR, 8'(8'h40 | (e << 4)), r);
      u_rpa_src.burst(n, 1 + int'(rnd() % 3));
      repeat (4) @(posedge aclk);
      ex = pre + n;
      rd(CNT_ADDR, d, r);
      chk(d, 32'(ex % 256));
      rd(FLAG_ADDR, d, r);
      chk(d & 32'h30, ex > 255 ? 32'h30 : 32'h10);
      chk({31'h0, irq_request}, 32'(msk != 0));
      wr(FLAG_ADDR, 8'h30, r);
      chk({31'h0, irq_request}, 32'h0);
    end
    wr(CTL_ADDR, 8'h00, r);
    wr(CNT_ADDR, 8'h33, r);
    wr(FLAG_ADDR, 8'h30, r);
    u_rpa_src.burst(3, 1);
    repeat (4) @(posedge aclk);
    rd(CNT_ADDR, d, r);
    chk(d, 32'h33);
    rd(FLAG_ADDR, d, r);
    chk(d & 32'h30, 32'h0);
    for (e = 0; e < 2; e++) begin
      u_rpa_src.hold(1'(e), 4);
      // control first: the previous gate may still be open on this pin level
      wr(CTL_ADDR, 8'(8'h60 | (e << 4)), r);
      wr(CNT_ADDR, 8'h00, r);
      // the next hold adds one edge, so the gate is open for exactly 640 edges
      u_rpa_src.hold(1'(1 - e), 639);
      u_rpa_src.hold(1'(e), 100);
      rd(CNT_ADDR, d, r);
      chk(d, 32'd10);
    end
    wr(CNT_ADDR, 8'h5a, r);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    tr = $time;
    rd(CNT_ADDR, d, r);
    chk(d, 32'h5a);
    rd(CTL_ADDR, d, r);
    chk(d, 32'h0);
    // clock enable low freezes the main counter: 5 counting edges between the two captures
    rd(MAIN_ADDR, m, r);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (20) @(posedge aclk);
    ce <= 1'b1;
    rd(MAIN_ADDR, d, r);
    chk(32'(d[15:0] - m[15:0]), 32'd5);
    rd(FLAG_ADDR, d, r);
    chk(d & 32'h80, 32'h0);
    // wrap lands 65536 counting cycles plus the 20 frozen ones after release
    while ($time < tr + 64'd655600) @(posedge aclk);
    rd(FLAG_ADDR, d, r);
    chk(d & 32'h80, 32'h80);
    rd(MAIN_ADDR, d, r);
    chk(32'(d[15:0] < 16'h0020), 32'h1);
    final_report();
  end
endmodule

bind rpa_top rpa_sva #(.RTI_BASE_LOG2(RTI_BASE_LOG2)) u_rpa_sva (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .axi_in(axi_in), .axi_out(axi_out), .pulse_input_pin(pulse_input_pin), .irq_request(irq_request),
  .capture4_compare5_sel(capture4_compare5_sel), .porta_dir_bit7(porta_dir_bit7), .porta_dir_bit3(porta_dir_bit3));
